// file: fsr_failsafe_regs.sv
// Fail-safe register bank: group fault flags, monitor reactions, fail-safe machine settings and timers.
//
// How it works
// - The communication group flag at bit 23 is the OR of the CRC error and request error bits.
// - The safety-IO group flag at bit 21 is the OR of the power-good and reset-output diagnostic faults.
// - The voltage group flag at bit 20 is the OR of the over and under flags of all three monitors.
// - Group flags hold nothing of their own and drop only when every feeding bit is clear.
// - The reset pulse select at bit 17 gives a 10 ms pulse when 0 and 1.0 ms when 1, cleared at power-on.
// - The long timer disable bit lets the 8 s reset-low counter run when 0 and stops it when 1.
// - The four-bit fault counter field reads back the live fault counter value in binary.
// - Each monitor fault flag sets on detection and clears when the host writes one to it.
`timescale 1ns/100ps
`default_nettype none
module fsr_failsafe_regs #(
    parameter int unsigned PULSE_LONG_CYCLES = fsr_pkg::PULSE_LONG_CYCLES,
    parameter int unsigned PULSE_SHORT_CYCLES = fsr_pkg::PULSE_SHORT_CYCLES,
    parameter int unsigned LONG_TIMER_CYCLES = fsr_pkg::LONG_TIMER_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_comm_crc_error,
    input wire logic i_comm_request_error,
    input wire logic i_power_good_diag_fault,
    input wire logic i_reset_out_diag_fault,
    input wire logic [5:0] i_monitor_detect,
    input wire logic [3:0] i_fault_counter_value,
    input wire logic i_reset_request,
    input wire logic i_reset_pin_sense,
    output logic [15:0] o_rdata_ff,
    output logic o_rd_valid_ff,
    output logic o_comm_group_flag_ff,
    output logic o_safety_io_group_flag_ff,
    output logic o_voltage_group_flag_ff,
    output fsr_pkg::fsr_reaction_s o_reaction_ff,
    output fsr_pkg::fsr_fsm_cfg_s o_fsm_cfg_ff,
    output logic o_reset_output_n_ff,
    output logic o_long_timer_expired_ff
);
    generate
        if (PULSE_LONG_CYCLES < 1 || PULSE_LONG_CYCLES >= (1 << fsr_pkg::PULSE_CNT_W) ||
            PULSE_SHORT_CYCLES < 1 || PULSE_SHORT_CYCLES >= (1 << fsr_pkg::PULSE_CNT_W) ||
            LONG_TIMER_CYCLES < 2 || LONG_TIMER_CYCLES >= (1 << fsr_pkg::LONG_CNT_W)) begin : g_bad_param
            $error("fsr_failsafe_regs timing parameters do not fit the counters");
        end
    endgenerate

    localparam logic [17:0] PULSE_LONG_LOAD = PULSE_LONG_CYCLES[17:0] - 18'h0_0001;
    localparam logic [17:0] PULSE_SHORT_LOAD = PULSE_SHORT_CYCLES[17:0] - 18'h0_0001;
    localparam logic [27:0] LONG_LAST = LONG_TIMER_CYCLES[27:0] - 28'h000_0001;

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] idx);
        hit = (addr == idx);
    endfunction

    // Monitor flags with write-one-to-clear.
    logic [5:0] mon_flags;
    logic [5:0] mon_clear;

    always_comb begin
        mon_clear = 6'h00;
        if (i_wr_en && hit(i_addr, fsr_pkg::REG_MONITOR_STATUS)) begin
            mon_clear[fsr_pkg::MON_CORE_OVER] = i_wdata[fsr_pkg::POS_MON_CORE_OVER];
            mon_clear[fsr_pkg::MON_CORE_UNDER] = i_wdata[fsr_pkg::POS_MON_CORE_UNDER];
            mon_clear[fsr_pkg::MON_IO_OVER] = i_wdata[fsr_pkg::POS_MON_IO_OVER];
            mon_clear[fsr_pkg::MON_IO_UNDER] = i_wdata[fsr_pkg::POS_MON_IO_UNDER];
            mon_clear[fsr_pkg::MON_AUX_OVER] = i_wdata[fsr_pkg::POS_MON_AUX_OVER];
            mon_clear[fsr_pkg::MON_AUX_UNDER] = i_wdata[fsr_pkg::POS_MON_AUX_UNDER];
        end
    end

    fsr_sticky_flags #(
        .N(fsr_pkg::MON_COUNT),
        .RESET_VALUE(fsr_pkg::MON_RESET)
    ) u_mon_flags (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_detect(i_monitor_detect),
        .i_clear(mon_clear),
        .o_flags_ff(mon_flags)
    );

    // Group flags follow their sources every cycle; the register only times them to the clock.
    logic nxt_comm_group;
    logic nxt_io_group;
    logic nxt_volt_group;

    always_comb begin
        nxt_comm_group = i_comm_crc_error | i_comm_request_error;
        nxt_io_group = i_power_good_diag_fault | i_reset_out_diag_fault;
        nxt_volt_group = |mon_flags;
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_comm_group_flag_ff <= 1'b0;
            o_safety_io_group_flag_ff <= 1'b0;
            o_voltage_group_flag_ff <= 1'b1;
        end else begin
            o_comm_group_flag_ff <= nxt_comm_group;
            o_safety_io_group_flag_ff <= nxt_io_group;
            o_voltage_group_flag_ff <= nxt_volt_group;
        end
    end

    // Configuration registers.
    fsr_pkg::fsr_reaction_s nxt_reaction;
    fsr_pkg::fsr_fsm_cfg_s nxt_fsm_cfg;

    always_comb begin
        nxt_reaction = o_reaction_ff;
        nxt_fsm_cfg = o_fsm_cfg_ff;
        if (i_wr_en && hit(i_addr, fsr_pkg::REG_REACTION_CORE_IO)) begin
            nxt_reaction.core_over_reaction = i_wdata[fsr_pkg::POS_CORE_OVER_REACT +: 2];
            nxt_reaction.core_under_reaction = i_wdata[fsr_pkg::POS_CORE_UNDER_REACT +: 2];
            nxt_reaction.io_over_reaction = i_wdata[fsr_pkg::POS_IO_OVER_REACT +: 2];
            nxt_reaction.io_under_reaction = i_wdata[fsr_pkg::POS_IO_UNDER_REACT +: 2];
        end
        if (i_wr_en && hit(i_addr, fsr_pkg::REG_REACTION_AUX)) begin
            nxt_reaction.aux_over_reaction = i_wdata[fsr_pkg::POS_AUX_OVER_REACT +: 2];
            nxt_reaction.aux_under_reaction = i_wdata[fsr_pkg::POS_AUX_UNDER_REACT +: 2];
        end
        if (i_wr_en && hit(i_addr, fsr_pkg::REG_FSM_SETTINGS)) begin
            nxt_fsm_cfg.fault_counter_limit = i_wdata[fsr_pkg::POS_FAULT_LIMIT +: 2];
            nxt_fsm_cfg.reset_pulse_length_sel = i_wdata[fsr_pkg::POS_PULSE_SEL];
            nxt_fsm_cfg.long_timer_disable = i_wdata[fsr_pkg::POS_LONG_DISABLE];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_reaction_ff.core_over_reaction <= fsr_pkg::REACT_OVER_RESET;
            o_reaction_ff.core_under_reaction <= fsr_pkg::REACT_UNDER_RESET;
            o_reaction_ff.io_over_reaction <= fsr_pkg::REACT_OVER_RESET;
            o_reaction_ff.io_under_reaction <= fsr_pkg::REACT_UNDER_RESET;
            o_reaction_ff.aux_over_reaction <= fsr_pkg::REACT_OVER_RESET;
            o_reaction_ff.aux_under_reaction <= fsr_pkg::REACT_UNDER_RESET;
            o_fsm_cfg_ff.fault_counter_limit <= fsr_pkg::FAULT_LIMIT_RESET;
            o_fsm_cfg_ff.reset_pulse_length_sel <= fsr_pkg::PULSE_SEL_RESET;
            o_fsm_cfg_ff.long_timer_disable <= fsr_pkg::LONG_DISABLE_RESET;
        end else begin
            o_reaction_ff <= nxt_reaction;
            o_fsm_cfg_ff <= nxt_fsm_cfg;
        end
    end

    // Read port: one cycle of latency, unmapped indices read as zero.
    logic [15:0] nxt_rdata;
    logic nxt_rd_valid;

    always_comb begin
        nxt_rdata = o_rdata_ff;
        nxt_rd_valid = i_rd_en;
        if (i_rd_en) begin
            nxt_rdata = 16'h0000;
            case (i_addr)
                fsr_pkg::REG_GROUP_FLAGS: begin
                    nxt_rdata[fsr_pkg::POS_COMM_GROUP] = nxt_comm_group;
                    nxt_rdata[fsr_pkg::POS_SAFETY_IO_GROUP] = nxt_io_group;
                    nxt_rdata[fsr_pkg::POS_VOLTAGE_GROUP] = nxt_volt_group;
                end
                fsr_pkg::REG_REACTION_CORE_IO: begin
                    nxt_rdata[fsr_pkg::POS_CORE_OVER_REACT +: 2] = o_reaction_ff.core_over_reaction;
                    nxt_rdata[fsr_pkg::POS_CORE_UNDER_REACT +: 2] = o_reaction_ff.core_under_reaction;
                    nxt_rdata[fsr_pkg::POS_IO_OVER_REACT +: 2] = o_reaction_ff.io_over_reaction;
                    nxt_rdata[fsr_pkg::POS_IO_UNDER_REACT +: 2] = o_reaction_ff.io_under_reaction;
                end
                fsr_pkg::REG_REACTION_AUX: begin
                    nxt_rdata[fsr_pkg::POS_AUX_OVER_REACT +: 2] = o_reaction_ff.aux_over_reaction;
                    nxt_rdata[fsr_pkg::POS_AUX_UNDER_REACT +: 2] = o_reaction_ff.aux_under_reaction;
                end
                fsr_pkg::REG_FSM_SETTINGS: begin
                    nxt_rdata[fsr_pkg::POS_FAULT_LIMIT +: 2] = o_fsm_cfg_ff.fault_counter_limit;
                    nxt_rdata[fsr_pkg::POS_PULSE_SEL] = o_fsm_cfg_ff.reset_pulse_length_sel;
                    nxt_rdata[fsr_pkg::POS_LONG_DISABLE] = o_fsm_cfg_ff.long_timer_disable;
                    nxt_rdata[fsr_pkg::POS_FAULT_COUNT +: 4] = i_fault_counter_value;
                end
                fsr_pkg::REG_MONITOR_STATUS: begin
                    nxt_rdata[fsr_pkg::POS_MON_CORE_OVER] = mon_flags[fsr_pkg::MON_CORE_OVER];
                    nxt_rdata[fsr_pkg::POS_MON_CORE_UNDER] = mon_flags[fsr_pkg::MON_CORE_UNDER];
                    nxt_rdata[fsr_pkg::POS_MON_IO_OVER] = mon_flags[fsr_pkg::MON_IO_OVER];
                    nxt_rdata[fsr_pkg::POS_MON_IO_UNDER] = mon_flags[fsr_pkg::MON_IO_UNDER];
                    nxt_rdata[fsr_pkg::POS_MON_AUX_OVER] = mon_flags[fsr_pkg::MON_AUX_OVER];
                    nxt_rdata[fsr_pkg::POS_MON_AUX_UNDER] = mon_flags[fsr_pkg::MON_AUX_UNDER];
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_rdata_ff <= 16'h0000;
            o_rd_valid_ff <= 1'b0;
        end else begin
            o_rdata_ff <= nxt_rdata;
            o_rd_valid_ff <= nxt_rd_valid;
        end
    end

    // Reset pulse generator. The length is picked at pulse start, so a select change mid-pulse
    // takes effect on the next pulse only.
    fsr_pkg::fsr_pulse_e pulse_state_ff;
    fsr_pkg::fsr_pulse_e nxt_pulse_state;
    logic [17:0] pulse_cnt_ff;
    logic [17:0] nxt_pulse_cnt;
    logic nxt_reset_output_n;

    always_comb begin
        nxt_pulse_state = pulse_state_ff;
        nxt_pulse_cnt = pulse_cnt_ff;
        nxt_reset_output_n = 1'b1;
        case (pulse_state_ff)
            fsr_pkg::FSR_PULSE_IDLE: begin
                if (i_reset_request) begin
                    nxt_pulse_state = fsr_pkg::FSR_PULSE_LOW;
                    nxt_pulse_cnt = o_fsm_cfg_ff.reset_pulse_length_sel ? PULSE_SHORT_LOAD : PULSE_LONG_LOAD;
                    nxt_reset_output_n = 1'b0;
                end
            end
            fsr_pkg::FSR_PULSE_LOW: begin
                if (pulse_cnt_ff == 18'h0_0000) begin
                    nxt_pulse_state = fsr_pkg::FSR_PULSE_IDLE;
                end else begin
                    nxt_pulse_cnt = pulse_cnt_ff - 18'h0_0001;
                    nxt_reset_output_n = 1'b0;
                end
            end
            default: begin
                nxt_pulse_state = fsr_pkg::FSR_PULSE_IDLE;
                nxt_pulse_cnt = 18'h0_0000;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            pulse_state_ff <= fsr_pkg::FSR_PULSE_IDLE;
            pulse_cnt_ff <= 18'h0_0000;
            o_reset_output_n_ff <= 1'b1;
        end else begin
            pulse_state_ff <= nxt_pulse_state;
            pulse_cnt_ff <= nxt_pulse_cnt;
            o_reset_output_n_ff <= nxt_reset_output_n;
        end
    end

    // Reset-pin sense: three stages, a change counts once stages two and three agree.
    logic sense_s1_ff;
    logic sense_s2_ff;
    logic sense_s3_ff;
    logic sense_level_ff;
    logic nxt_sense_level;
    logic [27:0] long_cnt_ff;
    logic [27:0] nxt_long_cnt;
    logic nxt_long_expired;

    always_comb begin
        nxt_sense_level = (sense_s2_ff == sense_s3_ff) ? sense_s3_ff : sense_level_ff;
        nxt_long_cnt = long_cnt_ff;
        nxt_long_expired = 1'b0;
        if (sense_level_ff || o_fsm_cfg_ff.long_timer_disable) begin
            nxt_long_cnt = 28'h000_0000;
        end else if (long_cnt_ff != LONG_LAST) begin
            nxt_long_cnt = long_cnt_ff + 28'h000_0001;
            nxt_long_expired = (long_cnt_ff == LONG_LAST - 28'h000_0001);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            sense_s1_ff <= 1'b1;
            sense_s2_ff <= 1'b1;
            sense_s3_ff <= 1'b1;
            sense_level_ff <= 1'b1;
            long_cnt_ff <= 28'h000_0000;
            o_long_timer_expired_ff <= 1'b0;
        end else begin
            sense_s1_ff <= i_reset_pin_sense;
            sense_s2_ff <= sense_s1_ff;
            sense_s3_ff <= sense_s2_ff;
            sense_level_ff <= nxt_sense_level;
            long_cnt_ff <= nxt_long_cnt;
            o_long_timer_expired_ff <= nxt_long_expired;
        end
    end
endmodule // fsr_failsafe_regs
`default_nettype wire

// file: fsr_failsafe_regs_sva.sv
// Checker of the fail-safe register bank port behaviour.
`timescale 1ns/100ps
`default_nettype none
module fsr_failsafe_regs_sva #(
    parameter int unsigned PULSE_LONG_CYCLES = 20,
    parameter int unsigned PULSE_SHORT_CYCLES = 5
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_comm_crc_error,
    input wire logic i_comm_request_error,
    input wire logic i_power_good_diag_fault,
    input wire logic i_reset_out_diag_fault,
    input wire logic [5:0] i_monitor_detect,
    input wire logic [3:0] i_fault_counter_value,
    input wire logic i_reset_request,
    input wire logic [15:0] o_rdata_ff,
    input wire logic o_comm_group_flag_ff,
    input wire logic o_safety_io_group_flag_ff,
    input wire logic o_voltage_group_flag_ff,
    input wire fsr_pkg::fsr_reaction_s o_reaction_ff,
    input wire fsr_pkg::fsr_fsm_cfg_s o_fsm_cfg_ff,
    input wire logic o_reset_output_n_ff,
    input wire logic o_long_timer_expired_ff
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    logic [15:0] wd_q;
    logic sel_q;
    int unsigned low_cnt;
    // Counted, as the long pulse exceeds any repetition count.
    always_ff @(posedge i_clock) begin
        wd_q <= i_wdata;
        if (!i_nrst) begin
            low_cnt <= 0;
            sel_q <= 1'b0;
        end else begin
            low_cnt <= o_reset_output_n_ff ? 0 : low_cnt + 1;
            if (i_reset_request && o_reset_output_n_ff) begin
                sel_q <= o_fsm_cfg_ff.reset_pulse_length_sel;
            end
        end
    end
    a_comm_group_or: assert property (
        $past(i_nrst) |-> o_comm_group_flag_ff == ($past(i_comm_crc_error) | $past(i_comm_request_error)))
        else $error("comm group not OR of sources");
    a_io_group_or: assert property (
        $past(i_nrst) |-> o_safety_io_group_flag_ff == ($past(i_power_good_diag_fault) | $past(i_reset_out_diag_fault)))
        else $error("io group not OR of sources");
    a_volt_group_set: assert property (
        |i_monitor_detect |-> ##2 o_voltage_group_flag_ff)
        else $error("voltage group missed detect");
    a_volt_group_drop: assert property (
        $fell(o_voltage_group_flag_ff) |-> $past(i_wr_en, 2) && $past(i_addr, 2) == fsr_pkg::REG_MONITOR_STATUS)
        else $error("voltage group dropped unprompted");
    a_cfg_readback: assert property (
        $past(i_rd_en) && $past(i_addr) == fsr_pkg::REG_FSM_SETTINGS |-> o_rdata_ff[3:0] == $past(i_fault_counter_value)
        && o_rdata_ff[9] == $past(o_fsm_cfg_ff.reset_pulse_length_sel) && o_rdata_ff[4] == $past(o_fsm_cfg_ff.long_timer_disable))
        else $error("settings read data wrong");
    a_react_write: assert property (
        i_wr_en && i_addr == fsr_pkg::REG_REACTION_CORE_IO |=> {o_reaction_ff.core_over_reaction,
        o_reaction_ff.core_under_reaction, o_reaction_ff.io_over_reaction, o_reaction_ff.io_under_reaction}
        == {wd_q[15:12], wd_q[3:0]})
        else $error("reactions not stored");
    a_pulse_start: assert property (
        i_reset_request && o_reset_output_n_ff |=> !o_reset_output_n_ff)
        else $error("pulse did not start");
    a_pulse_length: assert property (
        $rose(o_reset_output_n_ff) |-> low_cnt == (sel_q ? PULSE_SHORT_CYCLES : PULSE_LONG_CYCLES))
        else $error("pulse length wrong");
    a_long_disabled: assert property (
        o_long_timer_expired_ff |-> !$past(o_fsm_cfg_ff.long_timer_disable))
        else $error("long timer expired while disabled");
endmodule // fsr_failsafe_regs_sva
bind fsr_failsafe_regs fsr_failsafe_regs_sva #(
    .PULSE_LONG_CYCLES(PULSE_LONG_CYCLES),
    .PULSE_SHORT_CYCLES(PULSE_SHORT_CYCLES)
) fsr_failsafe_regs_sva_i (.*);
`default_nettype wire

// file: fsr_failsafe_regs_tb.sv
// Self-checking testbench of the fail-safe register bank.
`timescale 1ns/100ps
`default_nettype none
module fsr_failsafe_regs_tb;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic i_wr_en, i_rd_en, i_reset_request, i_reset_pin_sense, o_rd_valid_ff;
    logic o_comm_group_flag_ff, o_safety_io_group_flag_ff, o_voltage_group_flag_ff;
    logic o_reset_output_n_ff, o_long_timer_expired_ff;
    logic [3:0] i_addr, i_fault_counter_value, flt;
    logic [15:0] i_wdata, o_rdata_ff;
    logic [5:0] i_monitor_detect;
    fsr_pkg::fsr_reaction_s o_reaction_ff;
    fsr_pkg::fsr_fsm_cfg_s o_fsm_cfg_ff;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #20 i_clock = ~i_clock;
    fsr_failsafe_regs #(.PULSE_LONG_CYCLES(20), .PULSE_SHORT_CYCLES(5), .LONG_TIMER_CYCLES(30)) fsr_failsafe_regs_i (
        .*, .i_comm_crc_error(flt[3]), .i_comm_request_error(flt[2]), .i_power_good_diag_fault(flt[1]),
        .i_reset_out_diag_fault(flt[0]));
    fsr_host_model fsr_host_model_i (.i_clock, .i_rd_valid(o_rd_valid_ff), .i_rdata(o_rdata_ff),
        .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic hw(input logic [3:0] a, input logic [15:0] d);
        fsr_host_model_i.write_reg(a, d);
    endtask
    task automatic hr(input logic [3:0] a, output logic [15:0] d);
        fsr_host_model_i.read_reg(a, d);
    endtask
    task automatic t_reset();
        logic [15:0] d;
        logic [15:0] rv [6];
        rv = '{16'h1000, 16'hD00D, 16'h000D, 16'h4000, 16'h5010, 16'h0000};
        for (int i = 0; i < 6; i++) begin
            hr((i == 5) ? 4'h9 : 4'(i), d);
            check("reset value", d, rv[i]);
        end
        $display("reset value test done");
    endtask
    task automatic t_group();
        logic [15:0] d;
        for (int i = 0; i < 4; i++) begin
            flt = 4'h8 >> i;
            tick(2);
            check("comm group", o_comm_group_flag_ff, i < 2);
            check("io group", o_safety_io_group_flag_ff, i >= 2);
            hr(4'h0, d);
            check("group read", d, (i < 2) ? 16'h9000 : 16'h3000);
        end
        flt = 4'h0;
        tick(2);
        check("groups clear", {o_comm_group_flag_ff, o_safety_io_group_flag_ff}, 16'h0000);
        $display("group flag test done");
    endtask
    task automatic t_monitor();
        logic [15:0] d;
        logic [15:0] m;
        int unsigned mpos [6];
        mpos = '{15, 14, 13, 12, 5, 4};
        hw(4'h4, 16'hF030);
        hr(4'h4, d);
        check("monitor clear", d, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            tick(2);
            check("voltage clear", o_voltage_group_flag_ff, 1'b0);
            m = 16'h0001 << mpos[i];
            i_monitor_detect = 6'h01 << i;
            tick(1);
            i_monitor_detect = 6'h00;
            tick(1);
            check("voltage set", o_voltage_group_flag_ff, 1'b1);
            hw(4'h4, ~m);
            hr(4'h4, d);
            check("monitor held", d, m);
            hw(4'h4, m);
            hr(4'h4, d);
            check("monitor cleared", d, 16'h0000);
        end
        $display("monitor flag test done");
    endtask
    task automatic t_react();
        logic [15:0] d;
        hw(4'h1, 16'h8005);
        hr(4'h1, d);
        check("reaction one", d, 16'h8005);
        hw(4'h1, 16'hFFFF);
        hw(4'h2, 16'h0FF6);
        hw(4'h0, 16'hFFFF);
        hr(4'h1, d);
        check("reaction one reserved", d, 16'hF00F);
        hr(4'h2, d);
        check("reaction two", d, 16'h0006);
        check("reaction port", o_reaction_ff, 16'h0FF6);
        hr(4'h0, d);
        check("group read only", d, 16'h0000);
        $display("reaction test done");
    endtask
    // A second request is sent mid-pulse; restarting would lengthen the measured pulse.
    task automatic pulse(input logic [15:0] exp);
        int n;
        n = 0;
        i_reset_request = 1'b1;
        tick(1);
        i_reset_request = 1'b0;
        tick(2);
        i_reset_request = 1'b1;
        tick(1);
        i_reset_request = 1'b0;
        while (o_reset_output_n_ff === 1'b0 && n < 100) begin
            tick(1);
            n++;
        end
        check("pulse length", 16'(n + 3), exp);
        tick(3);
    endtask
    task automatic t_fsm();
        logic [15:0] d;
        hw(4'h3, 16'hFFFF);
        for (int v = 0; v <= 12; v++) begin
            i_fault_counter_value = 4'(v);
            hr(4'h3, d);
            check("settings read", d, 16'hC210 | 16'(v));
        end
        check("settings port", o_fsm_cfg_ff, 16'h000F);
        pulse(16'd5);
        hw(4'h3, 16'h0000);
        pulse(16'd20);
        $display("settings and pulse test done");
    endtask
    task automatic t_long();
        int hits;
        i_reset_pin_sense = 1'b0;
        for (int k = 0; k < 2; k++) begin
            hits = 0;
            hw(4'h3, (k == 0) ? 16'h0010 : 16'h0000);
            repeat (60) begin
                tick(1);
                if (o_long_timer_expired_ff === 1'b1) hits++;
            end
            check("long timer", 16'(hits), 16'(k));
        end
        i_reset_pin_sense = 1'b1;
        tick(8);
        $display("long timer test done");
    endtask
    initial begin
        flt = 4'h0;
        i_monitor_detect = 6'h00;
        i_fault_counter_value = 4'h0;
        i_reset_request = 1'b0;
        i_reset_pin_sense = 1'b1;
        repeat (16) @(posedge i_clock);
        #1;
        i_nrst = 1'b1;
        t_reset();
        t_group();
        t_monitor();
        t_react();
        t_fsm();
        t_long();
        stop_test();
    end
endmodule // fsr_failsafe_regs_tb
`default_nettype wire

// file: fsr_host_model.sv
// Host model that issues register writes and reads on the decoded strobe port.
`timescale 1ns/100ps
`default_nettype none
module fsr_host_model (
    input wire logic i_clock,
    input wire logic i_rd_valid,
    input wire logic [15:0] i_rdata,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [3:0] o_addr,
    output logic [15:0] o_wdata
);
    initial {o_wr_en, o_rd_en, o_addr, o_wdata} = 22'h00_0000;
    // Released address and data are inverted so nothing leans on stale values.
    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        #1;
        o_wr_en = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clock);
        #1;
        o_wr_en = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clock);
        #1;
        o_rd_en = 1'b1;
        o_addr = a;
        @(posedge i_clock);
        #1;
        o_rd_en = 1'b0;
        o_addr = ~a;
        d = (i_rd_valid === 1'b1) ? i_rdata : 16'hxxxx;
    endtask
endmodule // fsr_host_model
`default_nettype wire

// file: fsr_pkg.sv
// Package with register indices, field positions, reset values, timing and carrier types of the fail-safe bank.
package fsr_pkg;

    localparam int unsigned CLOCK_HZ = 25_000_000;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    localparam logic [3:0] REG_GROUP_FLAGS = 4'h0;
    localparam logic [3:0] REG_REACTION_CORE_IO = 4'h1;
    localparam logic [3:0] REG_REACTION_AUX = 4'h2;
    localparam logic [3:0] REG_FSM_SETTINGS = 4'h3;
    localparam logic [3:0] REG_MONITOR_STATUS = 4'h4;

    // Field positions inside a 16-bit word; word bit 15 stands for frame bit 23.
    localparam int unsigned POS_COMM_GROUP = 15;
    localparam int unsigned POS_SAFETY_IO_GROUP = 13;
    localparam int unsigned POS_VOLTAGE_GROUP = 12;
    localparam int unsigned POS_CORE_OVER_REACT = 14;
    localparam int unsigned POS_CORE_UNDER_REACT = 12;
    localparam int unsigned POS_IO_OVER_REACT = 2;
    localparam int unsigned POS_IO_UNDER_REACT = 0;
    localparam int unsigned POS_AUX_OVER_REACT = 2;
    localparam int unsigned POS_AUX_UNDER_REACT = 0;
    localparam int unsigned POS_FAULT_LIMIT = 14;
    localparam int unsigned POS_PULSE_SEL = 9;
    localparam int unsigned POS_LONG_DISABLE = 4;
    localparam int unsigned POS_FAULT_COUNT = 0;
    localparam int unsigned POS_MON_CORE_OVER = 15;
    localparam int unsigned POS_MON_CORE_UNDER = 14;
    localparam int unsigned POS_MON_IO_OVER = 13;
    localparam int unsigned POS_MON_IO_UNDER = 12;
    localparam int unsigned POS_MON_AUX_OVER = 5;
    localparam int unsigned POS_MON_AUX_UNDER = 4;

    // Monitor flag indices in the sticky flag vector.
    localparam int unsigned MON_COUNT = 6;
    localparam int unsigned MON_CORE_OVER = 0;
    localparam int unsigned MON_CORE_UNDER = 1;
    localparam int unsigned MON_IO_OVER = 2;
    localparam int unsigned MON_IO_UNDER = 3;
    localparam int unsigned MON_AUX_OVER = 4;
    localparam int unsigned MON_AUX_UNDER = 5;

    localparam logic [5:0] MON_RESET = 6'h2a;
    localparam logic [1:0] REACT_OVER_RESET = 2'h3;
    localparam logic [1:0] REACT_UNDER_RESET = 2'h1;
    localparam logic [1:0] FAULT_LIMIT_RESET = 2'h1;
    localparam logic PULSE_SEL_RESET = 1'b0;
    localparam logic LONG_DISABLE_RESET = 1'b0;

    localparam int unsigned PULSE_LONG_US = 10_000;
    localparam int unsigned PULSE_SHORT_US = 1_000;
    localparam int unsigned LONG_TIMER_S = 8;
    localparam int unsigned PULSE_LONG_CYCLES = PULSE_LONG_US * (CLOCK_HZ / 1_000_000);
    localparam int unsigned PULSE_SHORT_CYCLES = PULSE_SHORT_US * (CLOCK_HZ / 1_000_000);
    localparam int unsigned LONG_TIMER_CYCLES = LONG_TIMER_S * CLOCK_HZ;
    localparam int unsigned PULSE_CNT_W = 18;
    localparam int unsigned LONG_CNT_W = 28;

    typedef struct packed {
        logic [1:0] core_over_reaction;
        logic [1:0] core_under_reaction;
        logic [1:0] io_over_reaction;
        logic [1:0] io_under_reaction;
        logic [1:0] aux_over_reaction;
        logic [1:0] aux_under_reaction;
    } fsr_reaction_s;

    typedef struct packed {
        logic [1:0] fault_counter_limit;
        logic reset_pulse_length_sel;
        logic long_timer_disable;
    } fsr_fsm_cfg_s;

    typedef enum logic [1:0] {
        FSR_PULSE_IDLE = 2'b01,
        FSR_PULSE_LOW = 2'b10
    } fsr_pulse_e;

endpackage

// file: fsr_sticky_flags.sv
// Bank of sticky monitor fault flags, set by detection and cleared by writing one.
`timescale 1ns/100ps
`default_nettype none
module fsr_sticky_flags #(
    parameter int unsigned N = 6,
    parameter logic [5:0] RESET_VALUE = 6'h00
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic [N-1:0] i_detect,
    input wire logic [N-1:0] i_clear,
    output logic [N-1:0] o_flags_ff
);
    logic [N-1:0] nxt_flags;

    generate
        if (N > 6) begin : g_bad_width
            $error("fsr_sticky_flags supports at most six flags");
        end
    endgenerate

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_flag
            // A detection in the clearing cycle keeps the flag set.
            assign nxt_flags[gi] = i_detect[gi] | (o_flags_ff[gi] & ~i_clear[gi]);
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_flags_ff <= RESET_VALUE[N-1:0];
        end else begin
            o_flags_ff <= nxt_flags;
        end
    end
endmodule // fsr_sticky_flags
`default_nettype wire
